// ### pkg/smia_pkg.sv
// Purpose: shared constants and types for switch memory indirect access
// Assumes: one reference clock, register port with two address bits
// Notes: counts are in reference-clock cycles

package smia_pkg;

	// ---------------------------------------------
	// register map and field positions
	// ---------------------------------------------
	localparam logic [1:0] REG_DATA = 2'h0;
	localparam logic [1:0] REG_ADDR = 2'h1;
	localparam logic [1:0] REG_CTRL = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int CTRL_RWS_BIT = 7;
	localparam int CTRL_MOC_LSB = 3;
	localparam int ADDR_UD_BIT = 7;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ---------------------------------------------
	// operation codes
	// ---------------------------------------------
	localparam logic [3:0] MOC_NOP = 4'h0;
	localparam logic [3:0] MOC_TRI_ONE = 4'hC;
	localparam logic [3:0] MOC_TRI_ALL = 4'hD;
	localparam logic [3:0] MOC_CM_DATA = 4'h9;
	localparam logic [2:0] MOC_CM_BOTH = 3'h7;

	// ---------------------------------------------
	// timing and sizes
	// ---------------------------------------------
	localparam int ACC_TIME_X10 = 95;
	localparam int ACC_CYCLES = ACC_TIME_X10 / 10;
	localparam int TRI_RESET_CYCLES = 1035;
	localparam int DM_DEPTH = 128;
	localparam int CM_DEPTH = 256;

	typedef enum logic [1:0] {
		SMIA_IDLE = 2'b00,
		SMIA_RUN = 2'b01,
		SMIA_DONE = 2'b11
	} smia_state_e;

	typedef enum logic [1:0] {
		SMIA_FN_UNASSIGNED = 2'h0,
		SMIA_FN_SWITCHED = 2'h1,
		SMIA_FN_PREPROC = 2'h2,
		SMIA_FN_UP = 2'h3
	} smia_fn_e;

	typedef struct packed {
		logic read_write_select;
		logic [3:0] mem_op_code;
		logic [3:0] cmc;
	} smia_cmd_s;

	typedef struct packed {
		logic txd;
		logic txd_oe;
		logic tristate_ctl_n;
	} smia_pcm_pins_s;

	// control byte split; op code and function code share bit 3
	function automatic smia_cmd_s smia_decode(input logic [7:0] c);
		smia_cmd_s r;
		r.read_write_select = c[CTRL_RWS_BIT];
		r.mem_op_code = c[CTRL_MOC_LSB +: 4];
		r.cmc = c[3:0];
		return r;
	endfunction : smia_decode

	function automatic smia_fn_e smia_classify(input logic [3:0] code);
		smia_fn_e f;
		if (code == 4'h0) begin
			f = SMIA_FN_UNASSIGNED;
		end else if (code == 4'h9) begin
			f = SMIA_FN_UP;
		end else if (code[3]) begin
			f = SMIA_FN_PREPROC;
		end else begin
			f = SMIA_FN_SWITCHED;
		end
		return f;
	endfunction : smia_classify

endpackage : smia_pkg

// ### rtl/smia_pcm_tx.sv
// Purpose: upstream transmit serialiser with per sub-timeslot tristate
// Assumes: bit_en marks one transmit bit; frame_start precedes bit 7 of slot 0
// Notes: pin outputs are registered

`timescale 1ns/1ps

module smia_pcm_tx
	import smia_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rst_n, // async reset
	input wire logic ce, // clock enable
	input wire logic bit_en, // one per transmit bit
	input wire logic frame_start, // restart at slot 0
	input wire logic [7:0] slot_byte, // stored byte of current slot
	input wire logic [3:0] slot_tri, // tristate bits of current slot
	output logic [6:0] slot_idx, // slot being sent
	output smia_pkg::smia_pcm_pins_s pins // registered pin group
);
	logic [2:0] bit_q;
	logic [6:0] slot_q;
	logic drive;

	assign slot_idx = slot_q;
	// one control bit per two data bits
	assign drive = slot_tri[bit_q[2:1]];

	// ---------------------------------------------
	// position counters
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_q <= 3'h7;
			slot_q <= 7'h00;
		end else if (ce && bit_en) begin
			if (frame_start) begin
				bit_q <= 3'h7;
				slot_q <= 7'h00;
			end else begin
				bit_q <= bit_q - 3'h1;
				if (bit_q == 3'h0) begin
					slot_q <= slot_q + 7'h01;
				end
			end
		end
	end

	// ---------------------------------------------
	// pins
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '{txd: 1'b0, txd_oe: 1'b0, tristate_ctl_n: 1'b1};
		end else if (ce && bit_en && !frame_start) begin
			pins.txd <= drive & slot_byte[bit_q];
			pins.txd_oe <= drive;
			pins.tristate_ctl_n <= !drive;
		end
	end

	chk_tsc_follows_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pins.tristate_ctl_n == !pins.txd_oe)
		else $error("tristate control disagrees with driver enable");

	chk_float_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!pins.txd_oe |-> !pins.txd)
		else $error("data driven while floating");

	chk_sub_slot_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ce && bit_en && !frame_start) |=> pins.txd_oe == $past(slot_tri[bit_q[2:1]]))
		else $error("sub-timeslot enable mapped to wrong bit");

endmodule : smia_pcm_tx

// ### rtl/smia_top.sv
// Purpose: indirect command interpreter for switch data and control memories
// Assumes: register port, read data one cycle after read strobe
// Notes: single clock; ce low freezes every flop

`timescale 1ns/1ps

module smia_top
	import smia_pkg::*;
(
	input wire logic ref_clk, // reference clock
	input wire logic rst_n, // async reset
	input wire logic ce, // clock enable
	input wire logic [1:0] reg_addr, // register index
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic pcm_bit_en, // transmit bit strobe
	input wire logic pcm_frame_start, // transmit frame restart
	output smia_pkg::smia_pcm_pins_s pcm_pins, // transmit pins
	input wire logic [7:0] cfi_slot, // interface slot being served
	output smia_pkg::smia_fn_e cfi_func, // function of that slot
	output logic [7:0] cfi_value // data field of that slot
);
	import smia_pkg::*;

	// ---------------------------------------------
	// storage
	// ---------------------------------------------
	logic [7:0] dm_up [DM_DEPTH];
	logic [3:0] tri_mem [DM_DEPTH];
	logic [7:0] cm_data [CM_DEPTH];
	logic [3:0] cm_code [CM_DEPTH];

	logic [7:0] mem_access_data_reg_q;
	logic [7:0] mem_access_addr_reg_q;
	logic [7:0] mem_access_ctrl_reg_q;
	smia_cmd_s cmd_q;
	smia_state_e state_q;
	logic [10:0] cnt_q;
	logic [7:0] walk_q;
	logic mem_access_busy;
	logic start;
	logic done;
	logic [6:0] slot_addr;
	logic [6:0] tx_idx;

	assign mem_access_busy = (state_q != SMIA_IDLE);
	assign start = ce && reg_wr && reg_addr == REG_CTRL && !mem_access_busy;
	assign done = ce && state_q == SMIA_DONE;
	// upstream/downstream bit dropped for data memory slots
	assign slot_addr = mem_access_addr_reg_q[6:0];

	function automatic logic [7:0] sub_mask(input logic [3:0] mem_op_code);
		case (mem_op_code)
			4'h1: sub_mask = 8'hFF;
			4'h3: sub_mask = 8'hF0;
			4'h2: sub_mask = 8'h0F;
			4'h7: sub_mask = 8'hC0;
			4'h6: sub_mask = 8'h30;
			4'h5: sub_mask = 8'h0C;
			4'h4: sub_mask = 8'h03;
			default: sub_mask = 8'h00;
		endcase
	endfunction : sub_mask

	// ---------------------------------------------
	// address and control registers
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_access_addr_reg_q <= ADDR_RST;
		end else if (ce && reg_wr && reg_addr == REG_ADDR && !mem_access_busy) begin
			mem_access_addr_reg_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_access_ctrl_reg_q <= CTRL_RST;
			cmd_q <= smia_decode(CTRL_RST);
		end else if (start) begin
			mem_access_ctrl_reg_q <= reg_wdata;
			cmd_q <= smia_decode(reg_wdata);
		end
	end

	// ---------------------------------------------
	// command sequencer
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SMIA_IDLE;
			cnt_q <= 11'h000;
		end else if (ce) begin
			case (state_q)
				SMIA_IDLE: begin
					if (start) begin
						state_q <= SMIA_RUN;
						if (reg_wdata[CTRL_MOC_LSB +: 4] == MOC_TRI_ALL) begin
							cnt_q <= 11'(TRI_RESET_CYCLES - 2);
						end else begin
							cnt_q <= 11'(ACC_CYCLES - 2);
						end
					end
				end
				SMIA_RUN: begin
					if (cnt_q == 11'h000) begin
						state_q <= SMIA_DONE;
					end else begin
						cnt_q <= cnt_q - 11'h001;
					end
				end
				SMIA_DONE: begin
					state_q <= SMIA_IDLE;
				end
				default: begin
					state_q <= SMIA_IDLE;
				end
			endcase
		end
	end

	// walk index for the fill-all tristate command
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			walk_q <= 8'h00;
		end else if (ce) begin
			if (start) begin
				walk_q <= 8'h00;
			end else if (state_q == SMIA_RUN && !walk_q[7]) begin
				walk_q <= walk_q + 8'h01;
			end
		end
	end

	// ---------------------------------------------
	// data register: host writes and read-back
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_access_data_reg_q <= DATA_RST;
		end else if (ce) begin
			if (reg_wr && reg_addr == REG_DATA && !mem_access_busy) begin
				mem_access_data_reg_q <= reg_wdata;
			end else if (done && cmd_q.read_write_select) begin
				if (!cmd_q.mem_op_code[3]) begin
					mem_access_data_reg_q <= dm_up[slot_addr];
				end else if (cmd_q.mem_op_code == MOC_TRI_ONE) begin
					mem_access_data_reg_q <= {4'h0, tri_mem[slot_addr]};
				end else if (cmd_q.mem_op_code[3:1] == MOC_CM_BOTH) begin
					mem_access_data_reg_q <= {4'h0, cm_code[mem_access_addr_reg_q]};
				end else if (cmd_q.mem_op_code == MOC_CM_DATA) begin
					mem_access_data_reg_q <= cm_data[mem_access_addr_reg_q];
				end
			end
		end
	end

	// ---------------------------------------------
	// memory writes
	// ---------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (done && !cmd_q.read_write_select && !cmd_q.mem_op_code[3]) begin
			dm_up[slot_addr] <= (dm_up[slot_addr] & ~sub_mask(cmd_q.mem_op_code))
				| (mem_access_data_reg_q & sub_mask(cmd_q.mem_op_code));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (ce && state_q == SMIA_RUN && cmd_q.mem_op_code == MOC_TRI_ALL && !walk_q[7]) begin
			tri_mem[walk_q[6:0]] <= mem_access_data_reg_q[3:0];
		end else if (done && !cmd_q.read_write_select && cmd_q.mem_op_code == MOC_TRI_ONE) begin
			tri_mem[slot_addr] <= mem_access_data_reg_q[3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (done && !cmd_q.read_write_select) begin
			if (cmd_q.mem_op_code[3:1] == MOC_CM_BOTH) begin
				cm_data[mem_access_addr_reg_q] <= mem_access_data_reg_q;
				cm_code[mem_access_addr_reg_q] <= cmd_q.cmc;
			end else if (cmd_q.mem_op_code == MOC_CM_DATA) begin
				cm_data[mem_access_addr_reg_q] <= mem_access_data_reg_q;
			end
		end
	end

	// ---------------------------------------------
	// register read port
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			if (reg_rd) begin
				case (reg_addr)
					REG_DATA: reg_rdata <= mem_access_data_reg_q;
					REG_ADDR: reg_rdata <= mem_access_addr_reg_q;
					REG_CTRL: reg_rdata <= mem_access_ctrl_reg_q;
					REG_STATUS: reg_rdata <= 8'(mem_access_busy) << STATUS_BUSY_BIT;
					default: reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ---------------------------------------------
	// interface slot lookup
	// ---------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfi_func <= SMIA_FN_UNASSIGNED;
			cfi_value <= 8'h00;
		end else if (ce) begin
			cfi_func <= smia_classify(cm_code[cfi_slot]);
			cfi_value <= cm_data[cfi_slot];
		end
	end

	// ---------------------------------------------
	// transmit side
	// ---------------------------------------------
	smia_pcm_tx u_tx (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.bit_en(pcm_bit_en),
		.frame_start(pcm_frame_start),
		.slot_byte(dm_up[tx_idx]),
		.slot_tri(tri_mem[tx_idx]),
		.slot_idx(tx_idx),
		.pins(pcm_pins)
	);

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !ce);

	logic [10:0] busy_len_q;
	logic all_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len_q <= 11'h000;
			all_q <= 1'b0;
		end else if (ce) begin
			if (start) begin
				busy_len_q <= 11'h000;
				all_q <= reg_wdata[CTRL_MOC_LSB +: 4] == MOC_TRI_ALL;
			end else if (mem_access_busy) begin
				busy_len_q <= busy_len_q + 11'h001;
			end
		end
	end

	sequence single_op_s;
		mem_access_busy [*8] ##1 mem_access_busy ##1 !mem_access_busy;
	endsequence

	chk_busy_single_op: assert property (
		start && reg_wdata[CTRL_MOC_LSB +: 4] != MOC_TRI_ALL |=> single_op_s)
		else $error("single access busy length wrong");

	chk_fill_all_len: assert property (
		all_q && $fell(mem_access_busy) |-> busy_len_q == 11'(TRI_RESET_CYCLES))
		else $error("fill-all did not take 1035 cycles");

	chk_busy_locks: assert property (
		reg_wr && mem_access_busy |=> $stable(mem_access_data_reg_q)
			&& $stable(mem_access_addr_reg_q) && $stable(mem_access_ctrl_reg_q))
		else $error("register changed while busy");

	chk_tri_one_write: assert property (
		done && !cmd_q.read_write_select && cmd_q.mem_op_code == MOC_TRI_ONE
			|=> tri_mem[slot_addr] == mem_access_data_reg_q[3:0])
		else $error("tristate bits not stored");

	chk_tri_readback: assert property (
		done && cmd_q.read_write_select && cmd_q.mem_op_code == MOC_TRI_ONE
			|=> mem_access_data_reg_q == {4'h0, tri_mem[slot_addr]})
		else $error("tristate read-back wrong");

	chk_dm_readback: assert property (
		done && cmd_q.read_write_select && !cmd_q.mem_op_code[3] |=> mem_access_data_reg_q == dm_up[slot_addr])
		else $error("data memory read-back wrong");

	chk_cm_both: assert property (
		done && !cmd_q.read_write_select && cmd_q.mem_op_code[3:1] == MOC_CM_BOTH
			|=> cm_code[mem_access_addr_reg_q] == $past(cmd_q.cmc))
		else $error("function code not stored");

	chk_cm_data_only: assert property (
		done && !cmd_q.read_write_select && cmd_q.mem_op_code == MOC_CM_DATA
			|=> $stable(cm_code[mem_access_addr_reg_q]))
		else $error("data-only command changed code");

	chk_code_readback: assert property (
		done && cmd_q.read_write_select && cmd_q.mem_op_code[3:1] == MOC_CM_BOTH
			|=> mem_access_data_reg_q[7:4] == 4'h0)
		else $error("code read-back upper bits not clear");

endmodule : smia_top

// ### verif/smia_host_model.sv
// Purpose: host model issuing register cycles to the memory access block
// Assumes: tasks are entered right after a rising edge of ref_clk
// Notes: idle inserts wait cycles before each wr and rd strobe to act as a slow host; poll starts at once

`timescale 1ns/1ps

module smia_host_model (
	input wire logic ref_clk, // reference clock
	output logic [1:0] reg_addr, // register index
	output logic [7:0] reg_wdata, // write data
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata // read data, cycle after strobe
);
	import smia_pkg::*;

	int idle = 0;

	initial begin
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		repeat (idle) @(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		repeat (idle) @(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
	endtask : rd

	// status read every cycle until busy clears; nothing written meanwhile
	task automatic poll(output int n);
		n = 0;
		reg_addr <= REG_STATUS;
		reg_rd <= 1'b1;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (reg_rdata[STATUS_BUSY_BIT] !== 1'b0 && n < 2000);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : poll

endmodule : smia_host_model

// ### verif/switch_memory_indirect_access_test.sv
// Purpose: self-checking bench for the switch memory indirect access block
// Assumes: host model drives the register port; ce held high
// Notes: bench keeps its own images of tristate and data memory

`timescale 1ns/1ps

module switch_memory_indirect_access_test;
	import smia_pkg::*;

	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic pcm_bit_en = 1'b0;
	logic pcm_frame_start = 1'b0;
	logic [7:0] cfi_slot = 8'h00;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	smia_pcm_pins_s pcm_pins;
	smia_fn_e cfi_func;
	logic [7:0] cfi_value;
	int mismatches = 0;
	int total_checks = 0;
	logic [3:0] m_tri [128];
	logic [7:0] m_dm [128];
	logic [3:0] cm_codes [12] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4,
		4'h8, 4'hA, 4'hB, 4'h9};

	always #5 ref_clk = ~ref_clk;

	smia_host_model host (
		.ref_clk(ref_clk),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	smia_top DUT (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.pcm_bit_en(pcm_bit_en),
		.pcm_frame_start(pcm_frame_start),
		.pcm_pins(pcm_pins),
		.cfi_slot(cfi_slot),
		.cfi_func(cfi_func),
		.cfi_value(cfi_value)
	);

	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c,
		input int busy);
		int n;
		host.wr(REG_DATA, d);
		host.wr(REG_ADDR, a);
		host.wr(REG_CTRL, c);
		host.poll(n);
		chk("busy span", 8'h01, {7'h0, n >= busy && n <= busy + 2});
	endtask : cmd

	task automatic tri_check(input logic [6:0] s);
		logic [7:0] v;
		cmd(8'($urandom), {1'($urandom), s}, 8'hE0, ACC_CYCLES);
		host.rd(REG_DATA, v);
		chk("tristate field", {4'h0, m_tri[s]}, {4'h0, v[3:0]});
	endtask : tri_check

	function automatic logic [1:0] exp_fn(input logic [3:0] c);
		case (c)
			4'h0: return 2'h0;
			4'h9: return 2'h3;
			4'h8, 4'hA, 4'hB: return 2'h2;
			default: return 2'h1;
		endcase
	endfunction : exp_fn

	// sub-slot bits written by each data memory op code
	function automatic logic [7:0] sub_bits(input logic [3:0] c);
		case (c)
			4'h1: return 8'hFF;
			4'h3: return 8'hF0;
			4'h2: return 8'h0F;
			4'h7: return 8'hC0;
			4'h6: return 8'h30;
			4'h5: return 8'h0C;
			4'h4: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction : sub_bits

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] d;
		logic [7:0] d2;
		logic [7:0] a;
		logic [6:0] s;
		logic en;
		int k;
		void'($urandom(32'h541A));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			host.rd(2'(i), v);
			chk("reset value", 8'h00, v);
		end
		$display("test reset done");
		d = 8'($urandom);
		cmd(d, 8'($urandom), 8'h68, TRI_RESET_CYCLES);
		foreach (m_tri[i]) m_tri[i] = d[3:0];
		tri_check(7'h00);
		tri_check(7'h7F);
		$display("test fill all done");
		for (int i = 0; i < 8; i++) begin
			s = (i == 0) ? 7'h00 : 7'($urandom);
			d = (i == 0) ? 8'h06 : 8'($urandom);
			host.idle = i % 3;
			cmd(d, {1'($urandom), s}, 8'h60, ACC_CYCLES);
			m_tri[s] = d[3:0];
			tri_check(s);
		end
		host.idle = 0;
		$display("test single tristate done");
		host.wr(REG_DATA, 8'h09);
		host.wr(REG_ADDR, 8'hAA);
		host.wr(REG_CTRL, 8'h60);
		host.wr(REG_DATA, 8'hFF);
		host.wr(REG_CTRL, 8'h68);
		host.poll(k);
		host.rd(REG_DATA, v);
		chk("data held while busy", 8'h09, v);
		host.rd(REG_ADDR, v);
		chk("address held while busy", 8'hAA, v);
		m_tri[7'h2A] = 4'h9;
		tri_check(7'h2A);
		tri_check(7'h00);
		$display("test busy refusal done");
		for (int i = 0; i < 7; i++) begin
			s = 7'($urandom);
			d = 8'($urandom);
			d2 = 8'($urandom);
			cmd(d, {1'b1, s}, 8'h08, ACC_CYCLES);
			cmd(d2, {1'b1, s}, {1'b0, cm_codes[i + 1], 3'b000}, ACC_CYCLES);
			m_dm[s] = (d & ~sub_bits(cm_codes[i + 1])) | (d2 & sub_bits(cm_codes[i + 1]));
			cmd(8'($urandom), {1'($urandom), s}, {2'b10, 3'($urandom), 3'b000}, ACC_CYCLES);
			host.rd(REG_DATA, v);
			chk("data memory byte", m_dm[s], v);
		end
		$display("test data memory read done");
		cmd(8'hA5, 8'h80, 8'h08, ACC_CYCLES);
		m_dm[0] = 8'hA5;
		cmd(8'h09, 8'h80, 8'h60, ACC_CYCLES);
		m_tri[0] = 4'h9;
		cmd(8'h3C, 8'h81, 8'h08, ACC_CYCLES);
		m_dm[1] = 8'h3C;
		cmd(8'hF6, 8'h81, 8'h60, ACC_CYCLES);
		m_tri[1] = 4'h6;
		pcm_bit_en <= 1'b1;
		pcm_frame_start <= 1'b1;
		@(posedge ref_clk);
		pcm_frame_start <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			#1 k = 7 - i % 8;
			s = 7'(i / 8);
			en = m_tri[s][k / 2];
			chk("pcm pins", {5'h0, m_dm[s][k] & en, en, ~en}, {5'h0, pcm_pins});
		end
		@(posedge ref_clk);
		pcm_bit_en <= 1'b0;
		$display("test transmit done");
		foreach (cm_codes[i]) begin
			a = 8'($urandom);
			d = 8'($urandom);
			d2 = 8'($urandom);
			cmd(d, a, {4'h7, cm_codes[i]}, ACC_CYCLES);
			cfi_slot <= a;
			repeat (2) @(posedge ref_clk);
			#1;
			chk("slot function", {6'h0, exp_fn(cm_codes[i])}, {6'h0, cfi_func});
			chk("slot value", d, cfi_value);
			cmd(d2, a, 8'h48, ACC_CYCLES);
			cmd(8'($urandom), a, {4'hF, 4'($urandom)}, ACC_CYCLES);
			host.rd(REG_DATA, v);
			chk("function code", {4'h0, cm_codes[i]}, {4'h0, v[3:0]});
			cmd(8'($urandom), a, 8'hC8, ACC_CYCLES);
			host.rd(REG_DATA, v);
			chk("control data", d2, v);
		end
		$display("test control memory done");
		final_report();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		$display("mismatch watchdog expected finish seen timeout");
		final_report();
	end

endmodule : switch_memory_indirect_access_test
